//--- rtl/prvm_top.sv
// prvm_top: reset one-shot, halt and stop control, brownout reset, voltage detect register
// assumes the core decodes opcodes and presents register accesses on sys_clk;
// analog comparator outputs and watchdog timeout arrive asynchronously
// Summary of operation
// - reset delay timed by own rc-clock one-shot; execution held until it ends
// - one-shot starts on supply recovery, stop recovery with skip bit one, watchdog
// - one-shot interval lasts at least 2.5 ms
// - stop-mode control bit 5 decides whether one-shot runs after stop recovery
// - halt gates cpu clock; oscillator, timers and interrupts keep running
// - halt ends on taken enabled interrupt, resuming after halt, or on brownout or reset trigger
// - stop halts cpu clock and crystal oscillator
// - stop ends only by reset source; restart at address 000Ch
// - chip reset held while supply under brownout threshold; crystal stops
// - supply recovery runs full reset sequence then resumes
// - voltage detect register at 0Ch bank 0Dh; bit 0 enable, cleared at reset
// - bit 2 read-only high flag, set while supply above high threshold
// - bit 1 read-only low flag, set while supply below low threshold
// - enabled low flag sets request bit 5, latched until cleared
// - request 5 serviced only when mask enables it, else plain flag
// - no voltage detection during stop mode
// - one-time options for pull-ups, memory protection, watchdog at reset
`timescale 1ns/1ns
module prvm_top
   import prvm_pkg::*;
#(
   parameter int POR_COUNT = POR_CYCLES,     // one-shot length in rc ticks scaled to sys_clk
   parameter int RC_DIV    = RC_DIV_DEFAULT  // sys_clk cycles per rc tick
) (
   input  wire logic          sys_clk,               // system clock
   input  wire logic          reset,                 // synchronous reset, high
   input  wire prvm_analog_t  analog_in,             // comparator outputs, async
   input  wire logic          watchdog_timeout,      // watchdog timer expiry, async level
   input  wire logic          stop_recovery,         // stop recovery event, async level
   input  wire logic [7:0]    stop_mode_control,     // stop mode control register value
   input  wire logic          opcode_valid,          // opcode executes this cycle
   input  wire logic [7:0]    opcode,                // executing opcode
   input  wire logic          irq_taken,             // enabled interrupt acknowledged
   input  wire logic          irq_clear,             // instruction clears request bit 5
   input  wire logic [7:0]    interrupt_mask_register,  // interrupt mask
   input  wire prvm_reg_req_t reg_req,               // register access
   input  wire logic [3:0]    otp_pullup_nibbles,    // one-time pull-up options
   input  wire logic          otp_port2_pullup,      // one-time port 2 pull-up option
   input  wire logic          otp_protect,           // one-time memory protection
   input  wire logic          otp_watchdog_at_reset, // one-time watchdog enable at reset
   output logic [7:0]         reg_rdata,             // read data
   output logic               chip_reset,            // global reset, high
   output logic               cpu_clk_en,            // internal cpu clock gate
   output logic               xtal_en,               // crystal oscillator enable
   output logic               restart_valid,         // restart vector valid, pulse
   output logic [15:0]        restart_addr,          // restart vector
   output logic               low_supply_interrupt_request, // request bit 5 latch
   output logic               low_supply_irq_service,       // request 5 unmasked
   output logic [4:0]         pullup_enable,         // pull-up options applied
   output logic               protect_enable,        // memory protection applied
   output logic               watchdog_enable_at_reset // watchdog option at reset
);

   // ***************************************************
   // input synchronisers
   // ***************************************************
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic       supply_ok_s;
   logic       above_high_s;
   logic       below_low_s;
   logic       wdt_s;
   logic       smr_s;
   logic       wdt_d;
   logic       smr_d;
   logic       supply_d;

   always_ff @(posedge sys_clk) begin
      sync_a <= {analog_in.supply_ok, analog_in.above_high, analog_in.below_low,
                 watchdog_timeout, stop_recovery};
      sync_b <= sync_a;
      wdt_d    <= wdt_s;
      smr_d    <= smr_s;
      supply_d <= supply_ok_s;
   end
   assign {supply_ok_s, above_high_s, below_low_s, wdt_s, smr_s} = sync_b;

   // ***************************************************
   // mode control and reset one-shot
   // ***************************************************
   prvm_mode_t mode;
   prvm_mode_t next_mode;
   logic [31:0] por_cnt;
   logic [31:0] next_por_cnt;
   logic [15:0] rc_cnt;
   logic [15:0] next_rc_cnt;
   logic        por_busy;
   logic        next_por_busy;
   logic        trigger;
   logic        supply_rise;
   logic        smr_rise;
   logic        rst_q;
   logic        next_rst_q;
   logic        restart_q;
   logic        next_restart_q;

   assign supply_rise = supply_ok_s & ~supply_d;
   assign smr_rise    = smr_s & ~smr_d;
   // supply recovery, stop recovery with bit set, watchdog
   assign trigger = supply_rise
                  | (smr_rise & (mode == PRVM_STOP) & stop_mode_control[SMC_SKIP_BIT])
                  | (wdt_s & ~wdt_d);

   always_comb begin
      next_mode      = mode;
      next_por_cnt   = por_cnt;
      next_rc_cnt    = rc_cnt;
      next_por_busy  = por_busy;
      next_restart_q = 1'b0;
      if (trigger) begin
         next_por_busy = 1'b1;
         next_por_cnt  = 32'(POR_COUNT);
         next_rc_cnt   = 16'(RC_DIV - 1);
      end else if (por_busy) begin
         // rc-tick counting, independent of the crystal
         if (rc_cnt == 16'h_0000) begin
            next_rc_cnt = 16'(RC_DIV - 1);
            if (por_cnt <= 32'(RC_DIV)) begin
               next_por_cnt  = 32'h_0000_0000;
               next_por_busy = 1'b0;
            end else begin
               next_por_cnt = por_cnt - 32'(RC_DIV);
            end
         end else begin
            next_rc_cnt = rc_cnt - 16'h_0001;
         end
      end
      case (mode)
         PRVM_RUN: begin
            if (opcode_valid && !rst_q && opcode == OP_HALT) begin
               next_mode = PRVM_HALT;
            end else if (opcode_valid && !rst_q && opcode == OP_STOP) begin
               next_mode = PRVM_STOP;
            end
         end
         PRVM_HALT: begin
            if (irq_taken) begin
               next_mode = PRVM_RUN;
            end
         end
         PRVM_STOP: begin
            // leave only through a reset source
            if (trigger || (smr_rise && !stop_mode_control[SMC_SKIP_BIT])) begin
               next_mode      = PRVM_RUN;
               next_restart_q = 1'b1;
            end
         end
         default: next_mode = PRVM_RUN;
      endcase
      if (!supply_ok_s || trigger) begin
         if (mode == PRVM_STOP) begin
            next_restart_q = 1'b1;
         end
         next_mode = PRVM_RUN;
      end
      next_rst_q = ~supply_ok_s | next_por_busy;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode      <= PRVM_RUN;
         por_cnt   <= 32'(POR_COUNT);
         rc_cnt    <= 16'(RC_DIV - 1);
         por_busy  <= 1'b1;
         rst_q     <= 1'b1;
         restart_q <= 1'b0;
      end else begin
         mode      <= next_mode;
         por_cnt   <= next_por_cnt;
         rc_cnt    <= next_rc_cnt;
         por_busy  <= next_por_busy;
         rst_q     <= next_rst_q;
         restart_q <= next_restart_q;
      end
   end

   assign chip_reset    = rst_q;
   assign cpu_clk_en    = (mode == PRVM_RUN) & ~rst_q;
   assign xtal_en       = (mode != PRVM_STOP) & supply_ok_s;
   assign restart_valid = restart_q;
   assign restart_addr  = RESTART_ADDR;

   // ***************************************************
   // voltage detect register and request bit 5
   // ***************************************************
   logic vd_en;
   logic next_vd_en;
   logic high_supply_flag;
   logic next_high;
   logic low_flag;
   logic next_low;
   logic req5;
   logic next_req5;
   logic vd_sel;
   logic [7:0] next_rdata;
   logic       detect_on;

   assign vd_sel    = (reg_req.bank == VD_BANK) && (reg_req.addr == VD_OFFSET);
   assign detect_on = vd_en && (mode != PRVM_STOP);

   always_comb begin
      next_vd_en = vd_en;
      if (reg_req.wr && vd_sel) begin
         next_vd_en = reg_req.wdata[VD_EN_BIT];
      end
      next_high = detect_on & above_high_s;
      next_low  = detect_on & below_low_s;
      next_req5 = req5;
      if (irq_clear) begin
         next_req5 = 1'b0;
      end
      if (detect_on && low_flag) begin
         next_req5 = 1'b1;
      end
      next_rdata = 8'h_00;
      if (reg_req.rd && vd_sel) begin
         next_rdata[VD_EN_BIT]   = vd_en;
         next_rdata[VD_LOW_BIT]  = low_flag;
         next_rdata[VD_HIGH_BIT] = high_supply_flag;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || rst_q) begin
         vd_en            <= VD_RESET[VD_EN_BIT];
         high_supply_flag <= 1'b0;
         low_flag         <= 1'b0;
         req5             <= 1'b0;
         reg_rdata        <= VD_RESET;
      end else begin
         vd_en            <= next_vd_en;
         high_supply_flag <= next_high;
         low_flag         <= next_low;
         req5             <= next_req5;
         reg_rdata        <= next_rdata;
      end
   end

   assign low_supply_interrupt_request = req5;
   assign low_supply_irq_service = req5 & interrupt_mask_register[IRQ_LOW_BIT];

   // ***************************************************
   // one-time options
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pullup_enable            <= 5'h_00;
         protect_enable           <= 1'b0;
         watchdog_enable_at_reset <= 1'b0;
      end else begin
         pullup_enable            <= {otp_port2_pullup, otp_pullup_nibbles};
         protect_enable           <= otp_protect;
         watchdog_enable_at_reset <= otp_watchdog_at_reset;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   a_reset_during_brownout: assert property (@(posedge sys_clk) disable iff (reset)
      !supply_ok_s |=> chip_reset) else $error("reset not held in brownout");
   a_trigger_holds_reset: assert property (@(posedge sys_clk) disable iff (reset)
      trigger |=> chip_reset [*8]) else $error("reset released early");
   a_halt_gates_clock: assert property (@(posedge sys_clk) disable iff (reset)
      (mode == PRVM_HALT && supply_ok_s) |-> !cpu_clk_en && xtal_en)
      else $error("halt clocks wrong");
   a_halt_exit_irq: assert property (@(posedge sys_clk) disable iff (reset)
      (mode == PRVM_HALT && !irq_taken && supply_ok_s && !trigger) |=> mode == PRVM_HALT)
      else $error("halt left without interrupt");
   a_stop_xtal_off: assert property (@(posedge sys_clk) disable iff (reset)
      (mode == PRVM_STOP) |-> !xtal_en && !cpu_clk_en) else $error("stop clocks wrong");
   a_restart_vector: assert property (@(posedge sys_clk) disable iff (reset)
      restart_valid |-> $past(mode) == PRVM_STOP && restart_addr == RESTART_ADDR)
      else $error("restart without stop");
   a_no_detect_stop: assert property (@(posedge sys_clk) disable iff (reset)
      (mode == PRVM_STOP) |=> !high_supply_flag && !low_flag) else $error("detect in stop");
   a_req5_latches: assert property (@(posedge sys_clk) disable iff (reset || chip_reset)
      (req5 && !irq_clear) |=> req5) else $error("request 5 lost");
   a_req5_masked: assert property (@(posedge sys_clk) disable iff (reset)
      low_supply_irq_service |-> interrupt_mask_register[IRQ_LOW_BIT])
      else $error("request 5 served while masked");
   a_low_flag_source: assert property (@(posedge sys_clk) disable iff (reset || chip_reset)
      low_flag |-> $past(below_low_s) && $past(vd_en)) else $error("low flag spurious");

   c_halt_wake: cover property (@(posedge sys_clk) mode == PRVM_HALT ##1 mode == PRVM_RUN);
   c_stop_restart: cover property (@(posedge sys_clk) restart_valid);
   c_req5_set: cover property (@(posedge sys_clk) $rose(req5));
   c_retrigger: cover property (@(posedge sys_clk) por_busy && trigger);

endmodule // prvm_top

//--- rtl/prvm_pkg.sv
// prvm_pkg: constants and carrier types for the power, reset and voltage monitor
// assumes a 100 MHz sys_clk and an expanded register file access port from the core
package prvm_pkg;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int  CLK_MHZ          = 100;
   localparam int  POR_MIN_US       = 2500;                  // 2.5 ms least reset interval
   localparam int  POR_CYCLES       = POR_MIN_US * CLK_MHZ;  // rounded up, exact here
   localparam int  RC_DIV_DEFAULT   = 4;                     // rc oscillator stand-in divider

   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [3:0] VD_BANK       = 4'h_D;
   localparam logic [3:0] VD_OFFSET     = 4'h_C;
   localparam int         VD_EN_BIT     = 0;
   localparam int         VD_LOW_BIT    = 1;
   localparam int         VD_HIGH_BIT   = 2;
   localparam int         SMC_SKIP_BIT  = 5;
   localparam int         IRQ_LOW_BIT   = 5;
   localparam logic [7:0] VD_RESET      = 8'h_00;
   localparam logic [7:0] OP_HALT       = 8'h_7F;
   localparam logic [7:0] OP_STOP       = 8'h_6F;
   localparam logic [15:0] RESTART_ADDR = 16'h_000C;

   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [1:0] {PRVM_RUN, PRVM_HALT, PRVM_STOP} prvm_mode_t;

   typedef struct packed {
      logic       wr;      // write strobe
      logic       rd;      // read strobe
      logic [3:0] bank;    // expanded bank
      logic [3:0] addr;    // register in bank
      logic [7:0] wdata;   // write data
   } prvm_reg_req_t;

   typedef struct packed {
      logic       supply_ok;   // above brownout threshold
      logic       above_high;  // above high-detect threshold
      logic       below_low;   // below low-detect threshold
   } prvm_analog_t;

endpackage

//--- test/prvm_core_model.sv
// prvm_core_model: processor core stand-in that issues sleep opcodes and takes request 5
// assumes sys_clk is shared with the block and sleep requests come from the bench
`timescale 1ns/1ns
module prvm_core_model (
   input  wire logic       sys_clk,                // system clock
   input  wire logic       reset,                  // synchronous reset, high
   input  wire logic       sleep_req,              // bench asks for a sleep entry
   input  wire logic [7:0] sleep_op,               // sleep opcode to issue
   input  wire logic       low_supply_irq_service, // request 5 unmasked
   output logic            opcode_valid,           // opcode executes
   output logic [7:0]      opcode,                 // executing opcode
   output logic            irq_taken,              // interrupt acknowledged
   output logic            irq_clear               // service routine clears request
);
   logic pend;
   // ***************************************************
   // instruction stream and interrupt acceptance
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      opcode_valid <= 1'b0;
      opcode       <= ~opcode;   // opcode inverted outside valid; last opcode recurs every other cycle
      irq_taken    <= 1'b0;
      irq_clear    <= irq_taken;
      if (reset) begin
         pend   <= 1'b0;
         opcode <= 8'h_00;
      end else if (sleep_req) begin
         opcode_valid <= 1'b1;
         opcode       <= 8'h_FF;
         pend         <= 1'b1;
      end else if (pend) begin
         opcode_valid <= 1'b1;
         opcode       <= sleep_op;
         pend         <= 1'b0;
      end else if (low_supply_irq_service && !irq_taken && !irq_clear) begin
         irq_taken <= 1'b1;
      end
   end
endmodule // prvm_core_model

//--- test/test_power_reset_voltage_monitor.sv
// test_power_reset_voltage_monitor: self-checking bench for prvm_top
// assumes a shortened one-shot (POR_N cycles) and the core stand-in on the far side
`timescale 1ns/1ns
module test_power_reset_voltage_monitor;
   import prvm_pkg::*;
   localparam int POR_N = 40;
   localparam int DIV_N = 4;
   logic          sys_clk, reset, watchdog_timeout, stop_recovery, sleep_req;
   logic          opcode_valid, irq_taken, irq_clear, otp_port2_pullup, otp_protect;
   logic          otp_watchdog_at_reset, chip_reset, cpu_clk_en, xtal_en, restart_valid;
   logic          low_supply_interrupt_request, low_supply_irq_service, protect_enable;
   logic          watchdog_enable_at_reset;
   logic [7:0]    stop_mode_control, opcode, sleep_op, interrupt_mask_register, reg_rdata, d;
   logic [3:0]    otp_pullup_nibbles;
   logic [4:0]    pullup_enable;
   logic [15:0]   restart_addr;
   prvm_analog_t  analog_in;
   prvm_reg_req_t reg_req;
   int            n_mismatch, comparisons, cycles, n;
   logic [10:0]   rows [4] = '{{3'b100, 8'h01}, {3'b110, 8'h05}, {3'b101, 8'h03}, {3'b100, 8'h01}};

   prvm_top #(.POR_COUNT(POR_N), .RC_DIV(DIV_N)) u_prvm_top (
      .sys_clk(sys_clk), .reset(reset), .analog_in(analog_in),
      .watchdog_timeout(watchdog_timeout), .stop_recovery(stop_recovery),
      .stop_mode_control(stop_mode_control), .opcode_valid(opcode_valid), .opcode(opcode),
      .irq_taken(irq_taken), .irq_clear(irq_clear),
      .interrupt_mask_register(interrupt_mask_register), .reg_req(reg_req),
      .otp_pullup_nibbles(otp_pullup_nibbles), .otp_port2_pullup(otp_port2_pullup),
      .otp_protect(otp_protect), .otp_watchdog_at_reset(otp_watchdog_at_reset),
      .reg_rdata(reg_rdata), .chip_reset(chip_reset), .cpu_clk_en(cpu_clk_en),
      .xtal_en(xtal_en), .restart_valid(restart_valid), .restart_addr(restart_addr),
      .low_supply_interrupt_request(low_supply_interrupt_request),
      .low_supply_irq_service(low_supply_irq_service), .pullup_enable(pullup_enable),
      .protect_enable(protect_enable), .watchdog_enable_at_reset(watchdog_enable_at_reset));
   prvm_core_model u_prvm_core_model (.sys_clk(sys_clk), .reset(reset), .sleep_req(sleep_req),
      .sleep_op(sleep_op), .low_supply_irq_service(low_supply_irq_service),
      .opcode_valid(opcode_valid), .opcode(opcode), .irq_taken(irq_taken),
      .irq_clear(irq_clear));

   // ***************************************************
   // clock, timeout and helpers
   // ***************************************************
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic test_done();
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [3:0] b, input logic [3:0] a);
      @(posedge sys_clk) reg_req <= {1'b0, 1'b1, b, a, 8'h00};
      @(posedge sys_clk) reg_req <= '0;
      #1 d = reg_rdata;
   endtask
   task automatic wr(input logic [7:0] v);
      @(posedge sys_clk) reg_req <= {1'b1, 1'b0, VD_BANK, VD_OFFSET, v};
      @(posedge sys_clk) reg_req <= '0;
      #1;
   endtask
   task automatic wait_rel();
      n = 0;
      while (chip_reset !== 1'b0 && n < 200) begin
         tick(1);
         n++;
      end
   endtask
   task automatic sleep(input logic [7:0] op);
      @(posedge sys_clk) begin
         sleep_req <= 1'b1;
         sleep_op  <= op;
      end
      @(posedge sys_clk) sleep_req <= 1'b0;
      tick(3);
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      {watchdog_timeout, stop_recovery, sleep_req, otp_protect} = '0;
      {otp_port2_pullup, otp_watchdog_at_reset} = 2'b11;
      otp_pullup_nibbles = 4'hF;
      {stop_mode_control, sleep_op, interrupt_mask_register} = '0;
      analog_in = 3'b100;
      reg_req = '0;
      reset = 1'b1;
      tick(10);
      @(posedge sys_clk) reset <= 1'b0;
      wait_rel();
      chk(16'(n >= POR_N && n <= POR_N + DIV_N + 6), 16'h0001);
      rd(VD_BANK, VD_OFFSET);
      chk(d, VD_RESET);
      chk({pullup_enable, protect_enable, watchdog_enable_at_reset}, 16'h007D);
      wr(8'hFF);
      for (int i = 0; i < 4; i++) begin  // no low ports mode writes here
         @(posedge sys_clk) analog_in <= rows[i][10:8];
         tick(6);
         rd(VD_BANK, VD_OFFSET);
         chk(d, rows[i][7:0]);
      end
      rd(4'hE, VD_OFFSET);
      chk(d, 16'h0000);
      chk(low_supply_interrupt_request, 1'b1);
      chk(low_supply_irq_service, 1'b0);
      sleep(OP_HALT);
      tick(8);
      chk({cpu_clk_en, xtal_en}, 16'h0001);
      @(posedge sys_clk) interrupt_mask_register <= 8'h20;
      tick(4);
      chk({cpu_clk_en, low_supply_interrupt_request}, 16'h0002);
      @(posedge sys_clk) interrupt_mask_register <= 8'h00;
      sleep(OP_STOP);
      chk({cpu_clk_en, xtal_en}, 16'h0000);
      @(posedge sys_clk) analog_in <= 3'b101;
      tick(8);
      chk(low_supply_interrupt_request, 1'b0);
      @(posedge sys_clk) analog_in <= 3'b100;
      tick(6);
      @(posedge sys_clk) stop_recovery <= 1'b1;
      n = 0;
      while (restart_valid !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk(restart_valid, 1'b1);
      chk(restart_addr, RESTART_ADDR);
      chk(chip_reset, 1'b0);
      @(posedge sys_clk) stop_recovery <= 1'b0;
      tick(2);
      chk(cpu_clk_en, 1'b1);
      @(posedge sys_clk) stop_mode_control <= 8'h20;
      sleep(OP_STOP);
      @(posedge sys_clk) stop_recovery <= 1'b1;
      tick(6);
      chk(chip_reset, 1'b1);
      wait_rel();
      chk({chip_reset, cpu_clk_en}, 16'h0001);
      @(posedge sys_clk) stop_recovery <= 1'b0;
      @(posedge sys_clk) watchdog_timeout <= 1'b1;
      tick(20);
      @(posedge sys_clk) watchdog_timeout <= 1'b0;
      tick(3);
      @(posedge sys_clk) watchdog_timeout <= 1'b1;
      wait_rel();
      chk(16'(n >= POR_N && n < 200), 16'h0001);
      @(posedge sys_clk) analog_in <= 3'b000;
      tick(5);
      chk({chip_reset, xtal_en}, 16'h0002);
      @(posedge sys_clk) analog_in <= 3'b100;
      wait_rel();
      chk(16'(n >= POR_N && n < 200), 16'h0001);
      rd(VD_BANK, VD_OFFSET);
      chk(d, VD_RESET);
      test_done();
   end
endmodule // test_power_reset_voltage_monitor
